// File: rtl/irq_ctrl_map.vh
// Register map, field positions, reset values and timing counts
// Assumes a 32-bit Avalon-MM slave, one register per aligned word
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH

// Register indices; byte address is four times the index
`define IDX_IRQ_CONTROL 8'h0B
`define IDX_PERIPH_FLAG 8'h0C
`define IDX_PERIPH_ENABLE 8'h8C
`define IDX_OPTION 8'h81
`define IDX_CHANGE_MASK 8'h96

// irq_control_reg fields
`define BIT_GLOBAL_EN 7
`define BIT_PERIPH_EN 6
`define BIT_TIMER0_EN 5
`define BIT_PIN_EN 4
`define BIT_PORT_EN 3
`define BIT_TIMER0_FLAG 2
`define BIT_PIN_FLAG 1
`define BIT_PORT_FLAG 0

// peripheral_flag_reg and peripheral_enable_reg fields
`define BIT_EEPROM 7
`define BIT_CONV 6
`define BIT_COMP 3
`define BIT_TIMER1 0
`define PERIPH_IMPL_MASK 8'hC9

// Option register field
`define BIT_EDGE_POL 6

// Reset values
`define RST_IRQ_CONTROL 8'h00
`define RST_PERIPH_FLAG 8'h00
`define RST_PERIPH_ENABLE 8'h00
`define RST_CHANGE_MASK 6'h00
`define RST_EDGE_POL 1'b1

// Core interface constants
`define VECTOR_ADDR 13'h0004
`define PHASE_Q1 2'h0
`define PHASE_Q2 2'h1
`define LATENCY_TCY 2'h3

`endif

// File: rtl/mcu_interrupt_controller.v
// Interrupt controller for a small 8-bit core: flags, masks, vectoring, wake
// Assumes event inputs synchronous to i_clk_sys, four clocks per instruction
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "irq_ctrl_map.vh"

// What this block does
// - Seven sources: pin edge, timer0, port change, comparator, conversion, timer1, EEPROM.
// - Global enable set lets unmasked sources interrupt; clear blocks all delivery.
// - Every reset clears the global enable.
// - Return-from-service instruction sets the global enable again.
// - Taking an interrupt clears global enable, pushes return address, loads 0004h.
// - Latency three instruction cycles, or four for asynchronous events.
// - Each flag sets on its event regardless of any enable.
// - Clearing global enable drops pending delivery; flags stay pending for later.
// - Pin interrupt edge-triggered, polarity selectable, flag gated by pin enable.
// - Pin edge wakes sleeping core when pin enable set; global enable decides vectoring.
// - Timer0 rollover sets timer0 flag bit 2, gated by enable bit 5.
// - Masked port pin change sets port flag bit 0, gated by enable bit 3.
// - A change coinciding with a port read at Q2 may be missed.
// - Conversion done sets flag bit 6, gated by enable bit 6.
// - Peripheral wake leaves its peripheral flag bit reading one.
// - Pin flag sampled for recognition at every Q1.
// - Entry saves only the return program counter.
// - Full reset zeroes control register; other resets keep port flag.
// - Any enabled set flag wakes the core regardless of global enable.
// - On wake with global enable, prefetched instruction runs before the vector.
module mcu_interrupt_controller #(
	parameter PORT_W = 6
) (
	// Clock and resets
	input wire i_clk_sys,
	input wire i_sys_rst,
	input wire i_warm_rst,
	// Avalon-MM slave
	input wire [9:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	output reg [31:0] o_avs_readdata,
	output reg o_avs_waitrequest,
	// Event sources
	input wire i_external_irq_pin,
	input wire i_timer0_rollover,
	input wire [PORT_W-1:0] i_port_pins,
	input wire i_port_read,
	input wire i_comparator_change,
	input wire i_conversion_done,
	input wire i_timer1_overflow,
	input wire i_eeprom_write_done,
	// Core sequencer
	input wire i_sleep_active,
	input wire i_return_from_isr,
	input wire i_global_clear_instr,
	output reg o_irq_request_ff,
	output reg o_wake_ff,
	output reg o_vector_take_ff,
	output reg [12:0] o_vector_addr_ff,
	output reg [1:0] o_phase_ff
);

	reg [7:0] irq_control_ff;
	reg [7:0] periph_flag_ff;
	reg [7:0] periph_enable_ff;
	reg [PORT_W-1:0] change_mask_ff;
	reg edge_pol_ff;
	reg pin_prev_ff;
	reg [PORT_W-1:0] port_ref_ff;
	reg pending_ff;
	reg [1:0] lat_cnt_ff;
	reg [7:0] nxt_irq_control;
	reg [7:0] nxt_periph_flag;
	reg [31:0] nxt_readdata;
	reg any_pending;
	reg deliver;
	reg pin_edge;
	reg port_change;
	reg [7:0] periph_set;
	reg [7:0] reg_wdata;
	reg [7:0] index;
	reg aligned;
	reg bus_req;
	reg bus_ack;
	reg wr_ctrl;
	reg wr_pflag;
	reg wr_pen;
	reg wr_opt;
	reg wr_mask;

	// Bus decode: request answered one cycle after it is seen
	always @* begin
		index = i_avs_address[9:2];
		aligned = (i_avs_address[1:0] == 2'h0);
		bus_req = i_avs_read | i_avs_write;
		bus_ack = bus_req & ~o_avs_waitrequest;
		reg_wdata = i_avs_writedata[7:0];
		wr_ctrl = 1'b0;
		wr_pflag = 1'b0;
		wr_pen = 1'b0;
		wr_opt = 1'b0;
		wr_mask = 1'b0;
		if (bus_ack && i_avs_write && aligned) begin
			if (index == `IDX_IRQ_CONTROL) begin
				wr_ctrl = 1'b1;
			end else if (index == `IDX_PERIPH_FLAG) begin
				wr_pflag = 1'b1;
			end else if (index == `IDX_PERIPH_ENABLE) begin
				wr_pen = 1'b1;
			end else if (index == `IDX_OPTION) begin
				wr_opt = 1'b1;
			end else if (index == `IDX_CHANGE_MASK) begin
				wr_mask = 1'b1;
			end
		end
	end

	always @* begin
		nxt_readdata = 32'h00000000;
		if (!aligned) begin
			nxt_readdata = 32'h00000000;
		end else if (index == `IDX_IRQ_CONTROL) begin
			nxt_readdata[7:0] = irq_control_ff;
		end else if (index == `IDX_PERIPH_FLAG) begin
			nxt_readdata[7:0] = periph_flag_ff;
		end else if (index == `IDX_PERIPH_ENABLE) begin
			nxt_readdata[7:0] = periph_enable_ff;
		end else if (index == `IDX_OPTION) begin
			nxt_readdata[`BIT_EDGE_POL] = edge_pol_ff;
		end else if (index == `IDX_CHANGE_MASK) begin
			nxt_readdata[PORT_W-1:0] = change_mask_ff;
		end
	end

	always @(posedge i_clk_sys) begin
		if (i_sys_rst || i_warm_rst) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h00000000;
		end else begin
			o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
			if (bus_req && o_avs_waitrequest && i_avs_read) begin
				o_avs_readdata <= nxt_readdata;
			end
		end
	end

	// Event detection
	always @* begin
		pin_edge = edge_pol_ff ? (i_external_irq_pin & ~pin_prev_ff) : (~i_external_irq_pin & pin_prev_ff);
		port_change = |((i_port_pins ^ port_ref_ff) & change_mask_ff);
		if (i_port_read && o_phase_ff == `PHASE_Q2) begin
			port_change = 1'b0;
		end
		periph_set = 8'h00;
		periph_set[`BIT_EEPROM] = i_eeprom_write_done;
		periph_set[`BIT_CONV] = i_conversion_done;
		periph_set[`BIT_COMP] = i_comparator_change;
		periph_set[`BIT_TIMER1] = i_timer1_overflow;
	end

	// Pending term: flag and enable pairs
	always @* begin
		any_pending = (irq_control_ff[`BIT_TIMER0_FLAG] & irq_control_ff[`BIT_TIMER0_EN])
			| (irq_control_ff[`BIT_PIN_FLAG] & irq_control_ff[`BIT_PIN_EN])
			| (irq_control_ff[`BIT_PORT_FLAG] & irq_control_ff[`BIT_PORT_EN])
			| (irq_control_ff[`BIT_PERIPH_EN] & (|(periph_flag_ff & periph_enable_ff)));
		deliver = pending_ff & irq_control_ff[`BIT_GLOBAL_EN] & ~i_sleep_active;
	end

	// Control register next value; hardware set wins over software clear
	always @* begin
		nxt_irq_control = irq_control_ff;
		if (wr_ctrl) begin
			nxt_irq_control = reg_wdata;
		end
		if (i_return_from_isr) begin
			nxt_irq_control[`BIT_GLOBAL_EN] = 1'b1;
		end
		if (i_global_clear_instr) begin
			nxt_irq_control[`BIT_GLOBAL_EN] = 1'b0;
		end
		if (o_vector_take_ff) begin
			nxt_irq_control[`BIT_GLOBAL_EN] = 1'b0;
		end
		if (i_timer0_rollover) begin
			nxt_irq_control[`BIT_TIMER0_FLAG] = 1'b1;
		end
		if (pin_edge) begin
			nxt_irq_control[`BIT_PIN_FLAG] = 1'b1;
		end
		if (port_change) begin
			nxt_irq_control[`BIT_PORT_FLAG] = 1'b1;
		end
		nxt_periph_flag = periph_flag_ff;
		if (wr_pflag) begin
			nxt_periph_flag = reg_wdata & `PERIPH_IMPL_MASK;
		end
		nxt_periph_flag = nxt_periph_flag | periph_set;
	end

	always @(posedge i_clk_sys) begin
		// full reset zero, warm keeps port flag
		if (i_sys_rst) begin
			irq_control_ff <= `RST_IRQ_CONTROL;
			periph_flag_ff <= `RST_PERIPH_FLAG;
			periph_enable_ff <= `RST_PERIPH_ENABLE;
			change_mask_ff <= `RST_CHANGE_MASK;
			edge_pol_ff <= `RST_EDGE_POL;
			pin_prev_ff <= 1'b0;
			port_ref_ff <= {PORT_W{1'b0}};
		end else if (i_warm_rst) begin
			irq_control_ff <= {7'h00, irq_control_ff[`BIT_PORT_FLAG]};
			periph_flag_ff <= `RST_PERIPH_FLAG;
			periph_enable_ff <= `RST_PERIPH_ENABLE;
			change_mask_ff <= `RST_CHANGE_MASK;
			edge_pol_ff <= `RST_EDGE_POL;
			pin_prev_ff <= i_external_irq_pin;
			port_ref_ff <= i_port_pins;
		end else begin
			irq_control_ff <= nxt_irq_control;
			periph_flag_ff <= nxt_periph_flag;
			if (wr_pen) begin
				periph_enable_ff <= reg_wdata & `PERIPH_IMPL_MASK;
			end
			if (wr_mask) begin
				change_mask_ff <= reg_wdata[PORT_W-1:0];
			end
			if (wr_opt) begin
				edge_pol_ff <= reg_wdata[`BIT_EDGE_POL];
			end
			pin_prev_ff <= i_external_irq_pin;
			if (i_port_read && o_phase_ff == `PHASE_Q2) begin
				port_ref_ff <= i_port_pins;
			end
		end
	end

	// Phase counter, pending sample and latency count
	always @(posedge i_clk_sys) begin
		if (i_sys_rst || i_warm_rst) begin
			o_phase_ff <= `PHASE_Q1;
			pending_ff <= 1'b0;
			lat_cnt_ff <= 2'h0;
			o_irq_request_ff <= 1'b0;
			o_wake_ff <= 1'b0;
			o_vector_take_ff <= 1'b0;
			o_vector_addr_ff <= `VECTOR_ADDR;
		end else begin
			o_phase_ff <= o_phase_ff + 2'h1;
			o_vector_take_ff <= 1'b0;
			if (o_phase_ff == `PHASE_Q1) begin
				pending_ff <= any_pending;
			end
			o_irq_request_ff <= deliver & ~i_global_clear_instr;
			// wake needs sleep, enable and flag only
			o_wake_ff <= i_sleep_active & any_pending;
			if (!deliver || i_global_clear_instr || !nxt_irq_control[`BIT_GLOBAL_EN]) begin
				lat_cnt_ff <= 2'h0;
			end else if (o_phase_ff == `PHASE_Q1) begin
				if (lat_cnt_ff == `LATENCY_TCY - 2'h1) begin
					lat_cnt_ff <= 2'h0;
					o_vector_take_ff <= 1'b1;
					o_vector_addr_ff <= `VECTOR_ADDR;
				end else begin
					lat_cnt_ff <= lat_cnt_ff + 2'h1;
				end
			end
		end
	end

endmodule

// File: verif/core_seq_model.sv
// Core sequencer model: return stack depth, PC loaded at vector take, return pulses
// Assumes i_ret_cmd is a one-cycle request from the bench
`timescale 1ns/1ps
module core_seq_model (
	// Clock
	input wire i_clk_sys,
	// Controller side
	input wire i_vector_take,
	input wire [12:0] i_vector_addr,
	input wire i_ret_cmd,
	output reg o_return_from_isr,
	// Observed state
	output reg [3:0] o_depth,
	output reg [7:0] o_takes,
	output reg [12:0] o_pc
);
	initial begin
		o_return_from_isr = 1'h0;
		o_depth = 4'h0;
		o_takes = 8'h00;
		o_pc = 13'h0000;
	end
	always @(posedge i_clk_sys) begin
		o_return_from_isr <= i_ret_cmd;
		if (i_vector_take) begin
			o_depth <= o_depth + 4'h1;
			o_takes <= o_takes + 8'h01;
			o_pc <= i_vector_addr;
		end else if (i_ret_cmd && o_depth != 4'h0) begin
			o_depth <= o_depth - 4'h1;
		end
	end
endmodule

// File: verif/irq_ctrl_chk.sv
// Checker: bus handshake, vectoring, wake and phase relations at the ports
// Assumes a bind from the bench top onto the controller
`timescale 1ns/1ps
module irq_ctrl_chk (
	// Clock and resets
	input wire i_clk_sys,
	input wire i_sys_rst,
	input wire i_warm_rst,
	// Register bus
	input wire i_avs_read,
	input wire i_avs_write,
	input wire o_avs_waitrequest,
	// Core side
	input wire i_sleep_active,
	input wire i_global_clear_instr,
	input wire o_irq_request_ff,
	input wire o_wake_ff,
	input wire o_vector_take_ff,
	input wire [12:0] o_vector_addr_ff,
	input wire [1:0] o_phase_ff
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst || i_warm_rst);
	a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("bus request not answered in one cycle");
	a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_vector_fixed: assert property (o_vector_addr_ff == 13'h0004)
		else $error("vector address not 0004");
	a_take_pulse: assert property (o_vector_take_ff |=> !o_vector_take_ff)
		else $error("vector take longer than one cycle");
	a_take_needs_req: assert property (o_vector_take_ff |-> $past(o_irq_request_ff))
		else $error("vector taken without request");
	a_clear_blocks: assert property (i_global_clear_instr |=> !o_vector_take_ff [*8])
		else $error("take right after global clear");
	a_phase_steps: assert property (!$past(i_sys_rst) && !$past(i_warm_rst) |-> o_phase_ff == $past(o_phase_ff) + 2'h1)
		else $error("phase counter did not step");
	a_req_awake: assert property (o_irq_request_ff |-> !$past(i_sleep_active))
		else $error("request raised while asleep");
	a_wake_asleep: assert property (o_wake_ff |-> $past(i_sleep_active))
		else $error("wake raised while awake");
	a_reset_quiet: assert property ($fell(i_sys_rst) |-> o_avs_waitrequest && !o_vector_take_ff && !o_irq_request_ff)
		else $error("outputs not quiet after reset");
endmodule

// File: verif/tb.sv
// Bench: register access over the bus, event pulses, vectoring and wake
// Assumes the controller and the core model, checker bound below
`timescale 1ns/1ps
module tb;
	reg clk = 1'h0, rst = 1'h1, wrst = 1'h0, rd = 1'h0, wr = 1'h0, pin = 1'h0, pread = 1'h0;
	reg slp = 1'h0, gclr = 1'h0, ret_cmd = 1'h0;
	reg [9:0] addr = 10'h000;
	reg [31:0] wd = 32'h0, q;
	reg [4:0] ev = 5'h00;
	reg [5:0] pins = 6'h00;
	wire [31:0] rdata;
	wire wreq, irq, wake, take, ret;
	wire [12:0] vaddr, pc;
	wire [1:0] phase;
	wire [3:0] depth;
	wire [7:0] takes;
	integer err_total = 0, n_checks = 0, k;
	always #20 clk = ~clk;
	mcu_interrupt_controller uut (.i_clk_sys(clk), .i_sys_rst(rst), .i_warm_rst(wrst), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
		.i_external_irq_pin(pin), .i_timer0_rollover(ev[0]), .i_port_pins(pins), .i_port_read(pread),
		.i_comparator_change(ev[1]), .i_conversion_done(ev[2]), .i_timer1_overflow(ev[3]),
		.i_eeprom_write_done(ev[4]), .i_sleep_active(slp), .i_return_from_isr(ret), .i_global_clear_instr(gclr),
		.o_irq_request_ff(irq), .o_wake_ff(wake), .o_vector_take_ff(take), .o_vector_addr_ff(vaddr),
		.o_phase_ff(phase));
	core_seq_model core (.i_clk_sys(clk), .i_vector_take(take), .i_vector_addr(vaddr), .i_ret_cmd(ret_cmd),
		.o_return_from_isr(ret), .o_depth(depth), .o_takes(takes), .o_pc(pc));
	task results;
		begin
			if (err_total == 0 && n_checks > 0) $display("Testbench passed");
			else $display("Testbench failed");
			$finish;
		end
	endtask
	task chk(input [47:0] nm, input [31:0] exp, input [31:0] got);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[FAIL] %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task bus(input w, input [7:0] idx, input [7:0] d);
		begin
			@(posedge clk);
			addr <= {idx, 2'h0};
			wd <= {24'h0, d};
			rd <= !w;
			wr <= w;
			k = 0;
			@(posedge clk);
			while (wreq !== 1'h0 && k < 20) begin
				@(posedge clk);
				k = k + 1;
			end
			q = rdata;
			rd <= 1'h0;
			wr <= 1'h0;
			if (k >= 20) begin
				err_total = err_total + 1;
				results;
			end
		end
	endtask
	task rdchk(input [7:0] idx, input [31:0] exp, input [47:0] nm);
		begin
			bus(1'h0, idx, 8'h00);
			chk(nm, exp, q);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task rstp(input s);
		begin
			@(posedge clk);
			if (s) rst <= 1'h1;
			else wrst <= 1'h1;
			tick(2);
			rst <= 1'h0;
			wrst <= 1'h0;
		end
	endtask
	initial begin
		tick(2);
		rst <= 1'h0;
		rdchk(8'h0B, 32'h00, "ctrl");
		rdchk(8'h0C, 32'h00, "pflag");
		rdchk(8'h8C, 32'h00, "pen");
		rdchk(8'h81, 32'h40, "option");
		rdchk(8'h33, 32'h00, "unmap");
		ev <= 5'h1F;
		pin <= 1'h1;
		tick(1);
		ev <= 5'h00;
		tick(2);
		rdchk(8'h0B, 32'h06, "ctrl");
		rdchk(8'h0C, 32'hC9, "pflag");
		bus(1'h1, 8'h81, 8'h00);
		bus(1'h1, 8'h0B, 8'h00);
		rdchk(8'h0B, 32'h00, "ctrl");
		pin <= 1'h0;
		tick(3);
		rdchk(8'h0B, 32'h02, "ctrl");
		bus(1'h1, 8'h8C, 8'h40);
		bus(1'h1, 8'h0B, 8'h40);
		tick(40);
		chk("takes", 32'h0, takes);
		bus(1'h1, 8'h0B, 8'hC0);
		gclr <= 1'h1;
		tick(1);
		gclr <= 1'h0;
		tick(40);
		chk("takes", 32'h0, takes);
		rdchk(8'h0C, 32'hC9, "pflag");
		bus(1'h1, 8'h0B, 8'h80);
		tick(40);
		chk("takes", 32'h0, takes);
		bus(1'h1, 8'h0B, 8'hC0);
		k = 0;
		while (takes === 8'h00 && k < 40) begin
			@(posedge clk);
			k = k + 1;
		end
		chk("lat", 32'h1, k >= 12 && k <= 18);
		chk("pc", 32'h0004, pc);
		chk("depth", 32'h1, depth);
		rdchk(8'h0B, 32'h40, "ctrl");
		bus(1'h1, 8'h0C, 8'h00);
		ret_cmd <= 1'h1;
		tick(1);
		ret_cmd <= 1'h0;
		tick(40);
		rdchk(8'h0B, 32'hC0, "ctrl");
		chk("takes", 32'h1, takes);
		bus(1'h1, 8'h0B, 8'h20);
		slp <= 1'h1;
		ev <= 5'h01;
		tick(1);
		ev <= 5'h00;
		tick(4);
		chk("wake", 32'h1, wake);
		chk("irq", 32'h0, irq);
		slp <= 1'h0;
		bus(1'h1, 8'h0B, 8'h00);
		bus(1'h1, 8'h96, 8'h01);
		pins <= 6'h01;
		tick(3);
		rdchk(8'h0B, 32'h01, "ctrl");
		pins <= 6'h00;
		rstp(1'h0);
		rdchk(8'h0B, 32'h01, "ctrl");
		rstp(1'h1);
		rdchk(8'h0B, 32'h00, "ctrl");
		results;
	end
	initial begin
		tick(5000);
		err_total = err_total + 1;
		results;
	end
endmodule
bind mcu_interrupt_controller irq_ctrl_chk u_chk (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
	.i_warm_rst(i_warm_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_waitrequest(o_avs_waitrequest), .i_sleep_active(i_sleep_active),
	.i_global_clear_instr(i_global_clear_instr), .o_irq_request_ff(o_irq_request_ff), .o_wake_ff(o_wake_ff),
	.o_vector_take_ff(o_vector_take_ff), .o_vector_addr_ff(o_vector_addr_ff), .o_phase_ff(o_phase_ff));
